// ### rtl/wfc_pkg.sv
/*
  wfc_pkg: constants, register map and shared helpers for the wake-up
  frame filter configuration block.
  assumes: an 8-bit host bus with a 4-bit register offset and a 2-bit page
  number supplied by the page-select logic elsewhere in the device.
*/
`default_nettype none

package wfc_pkg;

  // ==========================================================================
  // pages and offsets
  localparam logic [1:0] PAGE_MIRROR = 2'h2;   // configuration mirrors
  localparam logic [1:0] PAGE_WAKE   = 2'h3;   // wake-up filter settings

  localparam logic [3:0] OFS_TX_CFG   = 4'hd;  // tx_config_readback
  localparam logic [3:0] OFS_DATA_CFG = 4'he;  // data_config_readback
  localparam logic [3:0] OFS_IRQ_MASK = 4'hf;  // irq_mask_readback
  localparam logic [3:0] OFS_MASK0    = 4'h1;  // wake_byte_mask_0
  localparam logic [3:0] OFS_MASK3    = 4'h4;  // wake_byte_mask_3
  localparam logic [3:0] OFS_SIG_LO   = 4'h5;  // wake_signature_pair_lo
  localparam logic [3:0] OFS_SIG_HI   = 4'h6;  // wake_signature_pair_hi
  localparam logic [3:0] OFS_START    = 4'h7;  // wake_pattern_start
  localparam logic [3:0] OFS_END      = 4'h8;  // wake_pattern_end

  // ==========================================================================
  // write-only register slots (index = offset - OFS_MASK0)
  localparam int NUM_WREG   = 8;
  localparam int NUM_FILTER = 4;
  localparam int SLOT_SIG_LO = 4;
  localparam int SLOT_SIG_HI = 5;
  localparam int SLOT_START  = 6;
  localparam int SLOT_END    = 7;

  // ==========================================================================
  // field layout and reset values
  localparam int          BYTE_W     = 8;
  localparam int          SIG_W      = 16;
  localparam int          IDX_W      = 11;     // frame byte index width
  localparam logic [IDX_W-1:0] MASK_SPAN = 11'h020;  // bytes per mask
  localparam logic [1:0]  LAST_LANE  = 2'h3;   // fourth write of a register
  localparam logic [31:0] WREG_RESET = 32'h0000_0000;
  localparam logic [7:0]  READ_ZERO  = 8'h00;
  localparam logic [15:0] CRC_INIT   = 16'h0000;
  // x^16 + x^15 + x^2 + 1, bit-reversed for lsb-first shifting
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001;

  // one-hot write strobe for the wake-up slots, zero when not mapped
  function automatic logic [NUM_WREG-1:0] wreg_onehot(
    input logic [1:0] page,
    input logic [3:0] ofs
  );
    logic [3:0] slot;
    slot = ofs - OFS_MASK0;
    if ((page == PAGE_WAKE) && (ofs >= OFS_MASK0) && (ofs <= OFS_END))
      return 8'h01 << slot[2:0];
    return 8'h00;
  endfunction

  // is frame byte idx covered by a filter's mask window
  function automatic logic byte_selected(
    input logic [IDX_W-1:0] idx,
    input logic [7:0]       start_words,
    input logic [7:0]       last_byte,
    input logic [31:0]      mask
  );
    logic [IDX_W-1:0] base;
    logic [IDX_W-1:0] rel;
    base = {2'h0, start_words, 1'b0};
    rel  = idx - base;
    return (idx >= base) && (rel < MASK_SPAN) && mask[rel[4:0]]
           && (idx <= {3'h0, last_byte});
  endfunction

endpackage : wfc_pkg

`default_nettype wire

// ### rtl/wfc_byte_loader.sv
/*
  wfc_byte_loader: assembles one 32-bit write-only register from four
  successive byte writes, least significant byte first.
  assumes: load is a one-cycle strobe on the same clock as byte_in.
*/
`timescale 1ns/100ps
`default_nettype none

module wfc_byte_loader
  import wfc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [7:0]  byte_in,
  output logic      [31:0] value,
  output logic      [1:0]  lane
);

  // ==========================================================================
  // lane counter: wraps after the fourth byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lane <= 2'h0;
    end else if (load) begin
      lane <= (lane == LAST_LANE) ? 2'h0 : lane + 2'h1;
    end
  end

  // ==========================================================================
  // byte lane store, zero from reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      value <= WREG_RESET;
    end else if (load) begin
      value[lane*BYTE_W +: BYTE_W] <= byte_in;
    end
  end

  // ==========================================================================
  // checks
  lane_wrap_a: assert property (@(posedge clock) disable iff (rst)
    load && (lane == LAST_LANE) |=> (lane == 2'h0))
    else $error("lane did not wrap after fourth byte");

  lane_fill_a: assert property (@(posedge clock) disable iff (rst)
    load |=> (value[$past(lane)*BYTE_W +: BYTE_W] == $past(byte_in)))
    else $error("byte not stored in its lane");

endmodule // wfc_byte_loader

`default_nettype wire

// ### rtl/wfc_crc16.sv
/*
  wfc_crc16: running 16-bit signature over selected frame bytes,
  generator x^16 + x^15 + x^2 + 1, lsb first.
  assumes: clear and enable come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module wfc_crc16
  import wfc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc
);

  // one byte of the reflected shift
  function automatic logic [15:0] crc_step(
    input logic [15:0] c_in,
    input logic [7:0]  d
  );
    logic [15:0] c;
    c = c_in;
    for (int b = 0; b < BYTE_W; b++) begin
      c = (c[0] ^ d[b]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction

  // ==========================================================================
  // signature register; clear wins over a byte in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crc <= CRC_INIT;
    end else if (clear) begin
      crc <= CRC_INIT;
    end else if (enable) begin
      crc <= crc_step(crc, data_in);
    end
  end

  // ==========================================================================
  // checks
  crc_hold_a: assert property (@(posedge clock) disable iff (rst)
    !clear && !enable |=> $stable(crc))
    else $error("signature changed with no selected byte");

endmodule // wfc_crc16

`default_nettype wire

// ### rtl/wfc_wakeup_filter_regs.sv
/*
  wfc_wakeup_filter_regs: wake-up frame filter settings, configuration
  mirrors and the masked signature match for four filters.
  assumes: host pins cs/rd/wr/offset/data are asynchronous to clock; page,
  mirror sources, filter enables and the frame byte stream come from logic
  on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module wfc_wakeup_filter_regs
  import wfc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  // host pins
  input  wire logic       host_cs_n,
  input  wire logic       host_rd_n,
  input  wire logic       host_wr_n,
  input  wire logic [3:0] host_offset,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe_n,
  // page select and mirror sources
  input  wire logic [1:0] reg_page,
  input  wire logic [7:0] tx_config,
  input  wire logic [7:0] data_config,
  input  wire logic [7:0] irq_mask,
  // filter enables from the command register
  input  wire logic [3:0] filter_enable,
  // received frame stream
  input  wire logic       frame_start,
  input  wire logic       frame_valid,
  input  wire logic [7:0] frame_byte,
  input  wire logic       frame_last,
  // result
  output logic      [3:0] wake_match
);

  // ==========================================================================
  // host pin synchronisers
  logic       cs_n_s1_reg;     // first stage, read only by second
  logic       cs_n_s2_reg;     // synchronised chip select
  logic       rd_n_s1_reg;     // first stage
  logic       rd_n_s2_reg;     // synchronised read strobe
  logic       wr_n_s1_reg;     // first stage
  logic       wr_n_s2_reg;     // synchronised write strobe
  logic       wr_n_d_reg;      // previous write strobe level
  logic       cs_n_d_reg;      // previous chip select level
  logic [3:0] ofs_s1_reg;      // first stage
  logic [3:0] ofs_s2_reg;      // synchronised offset
  logic [3:0] ofs_d_reg;       // offset held over the strobe edge
  logic [7:0] din_s1_reg;      // first stage
  logic [7:0] din_s2_reg;      // synchronised write data
  logic [7:0] din_d_reg;       // data held over the strobe edge

  // two flops on every host pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_n_s1_reg <= 1'b1;
      cs_n_s2_reg <= 1'b1;
      rd_n_s1_reg <= 1'b1;
      rd_n_s2_reg <= 1'b1;
      wr_n_s1_reg <= 1'b1;
      wr_n_s2_reg <= 1'b1;
      ofs_s1_reg  <= 4'h0;
      ofs_s2_reg  <= 4'h0;
      din_s1_reg  <= 8'h00;
      din_s2_reg  <= 8'h00;
    end else begin
      cs_n_s1_reg <= host_cs_n;
      cs_n_s2_reg <= cs_n_s1_reg;
      rd_n_s1_reg <= host_rd_n;
      rd_n_s2_reg <= rd_n_s1_reg;
      wr_n_s1_reg <= host_wr_n;
      wr_n_s2_reg <= wr_n_s1_reg;
      ofs_s1_reg  <= host_offset;
      ofs_s2_reg  <= ofs_s1_reg;
      din_s1_reg  <= host_data_in;
      din_s2_reg  <= din_s1_reg;
    end
  end

  // one-cycle delayed copies for edge detection and capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_n_d_reg <= 1'b1;
      cs_n_d_reg <= 1'b1;
      ofs_d_reg  <= 4'h0;
      din_d_reg  <= 8'h00;
    end else begin
      wr_n_d_reg <= wr_n_s2_reg;
      cs_n_d_reg <= cs_n_s2_reg;
      ofs_d_reg  <= ofs_s2_reg;
      din_d_reg  <= din_s2_reg;
    end
  end

  // ==========================================================================
  // write decode
  logic                write_done;   // end of a selected write strobe
  logic [NUM_WREG-1:0] slot_load;    // one-hot load per filter register

  // a write completes when the strobe rises while selected
  assign write_done = wr_n_s2_reg && !wr_n_d_reg && !cs_n_d_reg;

  // only page 3 slots load; mirror page writes fall through
  assign slot_load = write_done ? wreg_onehot(reg_page, ofs_d_reg)
                                : '0;

  // ==========================================================================
  // write-only filter registers
  logic [31:0] slot_value [NUM_WREG];  // assembled register contents

  // one byte loader per register slot
  for (genvar s = 0; s < NUM_WREG; s++) begin : g_slot
    wfc_byte_loader u_loader (
      .clock   (clock),
      .rst     (rst),
      .load    (slot_load[s]),
      .byte_in (din_d_reg),
      .value   (slot_value[s]),
      .lane    ()
    );
  end

  // ==========================================================================
  // per-filter field slicing
  logic [31:0] filt_mask  [NUM_FILTER];  // byte mask
  logic [15:0] filt_sig   [NUM_FILTER];  // expected signature
  logic [7:0]  filt_start [NUM_FILTER];  // start offset, 16-bit units
  logic [7:0]  filt_last  [NUM_FILTER];  // last frame byte position

  // slots 0..3 masks, then signature pairs, start and end bytes
  always_comb begin
    for (int f = 0; f < NUM_FILTER; f++) begin
      filt_mask[f]  = slot_value[f];
      filt_start[f] = slot_value[SLOT_START][f*BYTE_W +: BYTE_W];
      filt_last[f]  = slot_value[SLOT_END][f*BYTE_W +: BYTE_W];
    end
    filt_sig[0] = slot_value[SLOT_SIG_LO][15:0];
    filt_sig[1] = slot_value[SLOT_SIG_LO][31:16];
    filt_sig[2] = slot_value[SLOT_SIG_HI][15:0];
    filt_sig[3] = slot_value[SLOT_SIG_HI][31:16];
  end

  // ==========================================================================
  // host read path
  logic       read_active;   // synchronised read cycle in progress
  logic [7:0] read_data;     // value chosen for the addressed location

  assign read_active = !cs_n_s2_reg && !rd_n_s2_reg;

  // mirrors on page 2; filter registers read as zero
  always_comb begin
    read_data = READ_ZERO;
    if (reg_page == PAGE_MIRROR) begin
      unique case (ofs_s2_reg)
        OFS_TX_CFG:   read_data = tx_config;
        OFS_DATA_CFG: read_data = data_config;
        OFS_IRQ_MASK: read_data = irq_mask;
        default:      read_data = READ_ZERO;
      endcase
    end
  end

  // data bus driven while a read is selected
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      host_data_out  <= READ_ZERO;
      host_data_oe_n <= 1'b1;
    end else begin
      host_data_out  <= read_active ? read_data : READ_ZERO;
      host_data_oe_n <= !read_active;
    end
  end

  // ==========================================================================
  // frame byte index
  logic [IDX_W-1:0] byte_idx_reg;   // position of the current frame byte

  // counts valid bytes from each frame start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byte_idx_reg <= '0;
    end else if (frame_start) begin
      byte_idx_reg <= '0;
    end else if (frame_valid) begin
      byte_idx_reg <= byte_idx_reg + 11'h001;
    end
  end

  // ==========================================================================
  // masked signature per filter
  logic [NUM_FILTER-1:0] byte_sel;   // current byte enters the signature
  logic [15:0]           filt_crc [NUM_FILTER];  // running signatures

  for (genvar f = 0; f < NUM_FILTER; f++) begin : g_filter
    // window test on the current byte
    assign byte_sel[f] = frame_valid && byte_selected(byte_idx_reg,
                           filt_start[f], filt_last[f], filt_mask[f]);

    wfc_crc16 u_crc (
      .clock   (clock),
      .rst     (rst),
      .clear   (frame_start),
      .enable  (byte_sel[f]),
      .data_in (frame_byte),
      .crc     (filt_crc[f])
    );
  end

  // ==========================================================================
  // match decision one cycle after the final byte
  logic                  compare_pending_reg;  // signatures now complete
  logic [NUM_FILTER-1:0] sig_equal;            // signature equals expected

  always_comb begin
    for (int f = 0; f < NUM_FILTER; f++) begin
      sig_equal[f] = (filt_crc[f] == filt_sig[f]);
    end
  end

  // final byte seen, compare next cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      compare_pending_reg <= 1'b0;
    end else begin
      compare_pending_reg <= frame_valid && frame_last && !frame_start;
    end
  end

  // one-cycle match pulse, gated by the filter enables
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_match <= '0;
    end else if (compare_pending_reg) begin
      wake_match <= sig_equal & filter_enable;
    end else begin
      wake_match <= '0;
    end
  end

  // ==========================================================================
  // checks
  tx_mirror_a: assert property (@(posedge clock) disable iff (rst)
    read_active && (reg_page == PAGE_MIRROR) && (ofs_s2_reg == OFS_TX_CFG)
    |=> (host_data_out == $past(tx_config)) && !host_data_oe_n)
    else $error("tx config mirror read wrong");

  data_mirror_a: assert property (@(posedge clock) disable iff (rst)
    read_active && (reg_page == PAGE_MIRROR)
    && (ofs_s2_reg == OFS_DATA_CFG)
    |=> (host_data_out == $past(data_config)))
    else $error("data config mirror read wrong");

  irq_mirror_a: assert property (@(posedge clock) disable iff (rst)
    read_active && (reg_page == PAGE_MIRROR)
    && (ofs_s2_reg == OFS_IRQ_MASK)
    |=> (host_data_out == $past(irq_mask)))
    else $error("irq mask mirror read wrong");

  wo_read_a: assert property (@(posedge clock) disable iff (rst)
    read_active && (reg_page == PAGE_WAKE) |=> (host_data_out == READ_ZERO))
    else $error("write-only register returned data");

  mirror_ro_a: assert property (@(posedge clock) disable iff (rst)
    (reg_page != PAGE_WAKE) |-> (slot_load == '0))
    else $error("filter register loaded outside its page");

  enable_gate_a: assert property (@(posedge clock) disable iff (rst)
    (wake_match != '0) |-> ((wake_match & ~$past(filter_enable)) == '0))
    else $error("disabled filter reported a match");

  start_window_a: assert property (@(posedge clock) disable iff (rst)
    (byte_idx_reg < {2'h0, filt_start[0], 1'b0}) |-> !byte_sel[0])
    else $error("byte before start offset selected");

  match_pulse_a: assert property (@(posedge clock) disable iff (rst)
    frame_valid && frame_last && !frame_start && (filter_enable == 4'hf)
    ##1 (sig_equal == 4'hf) |=> (wake_match == 4'hf) ##1 (wake_match == '0))
    else $error("match pulse missing or too long");

endmodule // wfc_wakeup_filter_regs

`default_nettype wire

// ### verif/wfc_host_model.sv
/*
  wfc_host_model: host microcontroller on the byte-wide register pins.
  assumes: the block synchronises these pins to its clock; page is set by
  the bench and held across every strobe.
*/
`timescale 1ns/100ps
`default_nettype none

module wfc_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe_n,
  output logic            host_cs_n,
  output logic            host_rd_n,
  output logic            host_wr_n,
  output logic      [3:0] host_offset,
  output logic      [7:0] host_data_in
);
  // ==========================================================================
  // idle pins at time zero
  initial begin
    host_cs_n    = 1'b1;
    host_rd_n    = 1'b1;
    host_wr_n    = 1'b1;
    host_offset  = 4'h0;
    host_data_in = 8'h00;
  end

  // one byte write: strobe low 4 clocks, high 4 clocks, lines held
  task automatic write_byte(input logic [3:0] ofs, input logic [7:0] d);
    @(posedge clock);
    host_cs_n    <= 1'b0;
    host_wr_n    <= 1'b0;
    host_offset  <= ofs;
    host_data_in <= d;
    repeat (4) @(posedge clock);
    host_wr_n <= 1'b1;
    repeat (4) @(posedge clock);
    host_cs_n    <= 1'b1;
    host_offset  <= ~ofs;  // released lines show no stale value
    host_data_in <= ~d;
    repeat (2) @(posedge clock);
  endtask

  // full 32-bit register: four writes, least significant byte first
  task automatic write_word(input logic [3:0] ofs, input logic [31:0] w);
    for (int k = 0; k < 4; k++) begin
      write_byte(ofs, w[8*k +: 8]);
    end
  endtask

  // one byte read: hold select and strobe until data has settled
  task automatic read_byte(input logic [3:0] ofs, output logic [7:0] d,
                           output logic oe_n);
    @(posedge clock);
    host_cs_n   <= 1'b0;
    host_rd_n   <= 1'b0;
    host_offset <= ofs;
    repeat (5) @(posedge clock);
    d    = host_data_out;
    oe_n = host_data_oe_n;
    host_rd_n   <= 1'b1;
    host_cs_n   <= 1'b1;
    host_offset <= ~ofs;
    repeat (5) @(posedge clock);
  endtask
endmodule // wfc_host_model

`default_nettype wire

// ### verif/testbench.sv
/*
  testbench: random and corner checks of the wake-up filter settings.
  assumes: the host model drives the register pins; 40 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench
  import wfc_pkg::*;
;
  // ==========================================================================
  // signals
  logic        clock, rst, cs_n, rd_n, wr_n, oe_n;
  logic [3:0]  ofs, filter_enable, wake_match, seen;
  logic [7:0]  din, dout, tx_config, data_config, irq_mask, frame_byte;
  logic [1:0]  reg_page;
  logic        frame_start, frame_valid, frame_last;
  logic [7:0]  frame_mem [64];  // frame under test
  integer      seed = 61268;
  int          mismatches = 0;
  int          tests_run = 0;

  wfc_wakeup_filter_regs dut (.clock(clock), .rst(rst), .host_cs_n(cs_n),
    .host_rd_n(rd_n), .host_wr_n(wr_n), .host_offset(ofs),
    .host_data_in(din), .host_data_out(dout), .host_data_oe_n(oe_n),
    .reg_page(reg_page), .tx_config(tx_config), .data_config(data_config),
    .irq_mask(irq_mask), .filter_enable(filter_enable),
    .frame_start(frame_start), .frame_valid(frame_valid),
    .frame_byte(frame_byte), .frame_last(frame_last),
    .wake_match(wake_match));
  wfc_host_model host (.clock(clock), .host_data_out(dout),
    .host_data_oe_n(oe_n), .host_cs_n(cs_n), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .host_offset(ofs), .host_data_in(din));

  // ==========================================================================
  // clock and match collector
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  // gather every match pulse of the current frame
  always @(posedge clock) begin
    if (frame_start) seen <= 4'h0;
    else seen <= seen | wake_match;
  end

  // compare and count
  task automatic check(input string name, input logic [15:0] got,
                       input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // expected signature over the window of one filter
  function automatic logic [15:0] expect_sig(input logic [31:0] m,
    input logic [7:0] st, input logic [7:0] lb);
    logic [15:0] c;
    int          rel;
    c = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      rel = i - 2 * int'(st);
      if (rel >= 0 && rel < 32 && m[rel] && i <= int'(lb)) begin
        c = c ^ {8'h00, frame_mem[i]};
        for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    end
    return c;
  endfunction

  // one frame, then look for the pulses
  task automatic send_frame(input logic [3:0] exp);
    @(posedge clock);
    frame_start <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge clock);
      frame_start <= 1'b0;
      frame_valid <= 1'b1;
      frame_byte  <= frame_mem[i];
      frame_last  <= (i == 63);
    end
    @(posedge clock);
    frame_valid <= 1'b0;
    frame_last  <= 1'b0;
    frame_byte  <= ~frame_byte;
    repeat (6) @(posedge clock);
    check("wake_match", {12'h000, seen}, {12'h000, exp});
  endtask

  // program all four filters at random, one signature spoiled
  task automatic run_round(input int bad);
    logic [31:0] m [4];
    logic [7:0]  st [4], lb [4];
    logic [15:0] sig [4];
    logic [3:0]  en;
    for (int i = 0; i < 64; i++) frame_mem[i] = $random(seed);
    for (int f = 0; f < 4; f++) begin
      m[f]   = $random(seed);
      st[f]  = $random(seed) & 8'h07;
      lb[f]  = (f == 3) ? 8'h3f : ($random(seed) & 8'h3f);
      sig[f] = expect_sig(m[f], st[f], lb[f])
               ^ ((f == bad) ? 16'h0001 : 16'h0000);
      host.write_word(OFS_MASK0 + 4'(f), m[f]);
    end
    host.write_word(OFS_SIG_LO, {sig[1], sig[0]});
    host.write_word(OFS_SIG_HI, {sig[3], sig[2]});
    host.write_word(OFS_START, {st[3], st[2], st[1], st[0]});
    host.write_word(OFS_END, {lb[3], lb[2], lb[1], lb[0]});
    en = $random(seed);
    filter_enable <= en;
    send_frame(en & ~(4'h1 << bad));
    $display("test round %0d done", bad);
  endtask

  // read one location and compare, with the bus enable low
  task automatic read_check(input logic [3:0] o, input logic [7:0] exp);
    logic [7:0] d;
    logic       oe;
    host.read_byte(o, d, oe);
    check("read data", {8'h00, d}, {8'h00, exp});
    check("read enable", {15'h0000, oe}, 16'h0000);
    check("released enable", {15'h0000, oe_n}, 16'h0001);
  endtask

  // ==========================================================================
  // verdict
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    finish_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    reg_page = PAGE_WAKE;
    filter_enable = 4'hf;
    {frame_start, frame_valid, frame_last, frame_byte} = 11'h000;
    tx_config = $random(seed);
    data_config = $random(seed);
    irq_mask = $random(seed);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    // all zero after reset: empty window gives a zero signature
    for (int i = 0; i < 64; i++) frame_mem[i] = $random(seed);
    send_frame(4'hf);
    $display("test reset values done");
    read_check(OFS_MASK0, 8'h00);
    read_check(4'h0, 8'h00);
    reg_page <= PAGE_MIRROR;
    read_check(OFS_TX_CFG, tx_config);
    read_check(OFS_DATA_CFG, data_config);
    read_check(OFS_IRQ_MASK, irq_mask);
    host.write_byte(OFS_TX_CFG, ~tx_config);
    // filter offset written on the mirror page must not load
    host.write_byte(OFS_MASK0, 8'hff);
    read_check(OFS_TX_CFG, tx_config);
    read_check(4'h3, 8'h00);
    $display("test readback done");
    reg_page <= PAGE_WAKE;
    // filter 0 still all zero, so every filter still matches
    send_frame(4'hf);
    // partial word, then reset mid-run: value and lane start over
    host.write_byte(OFS_MASK0, 8'hff);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    send_frame(4'hf);
    $display("test mid-run reset done");
    for (int r = 0; r < 4; r++) run_round(r);
    finish_test();
  end
endmodule // testbench

`default_nettype wire
